// *** common/tmrv_pkg.sv ***
// Operation
// - Eight-bit up-counter clocked by selected source; software reads and writes it anytime.
// - Clear field: 00 never, 01 match A, 10 match B, 11 reset pin rise.
// - After reset-pin clear, trigger enable decides whether counting continues or stops.
// - Overflow from ff to 00 sets the overflow flag.
// - Counter resets to zero.
// - Compare constants A and B are read/write and reset to all ones.
// - Counter equal to constant A sets flag A; interrupt if enabled.
// - Constant B likewise sets flag B and its interrupt; compare B is not suppressed while constant B is written.
// - Compare A is suppressed while constant A is being written.
// - Control0 bit 7 enables flag B interrupt, bit 6 flag A interrupt.
// - Control0 bit 5 enables the overflow interrupt; resets to zero.
// - Clock select 001-011 pick prescaler taps /4 to /128, counted on falling edges.
// - Select 101,110,111 count external clock rise, fall, both; 000/100 stop.
// - Trigger pin edge, rising, falling or both, can start counting.
// - With trigger enabled, clearing halts the count until the next trigger.
// - Matches A and B drive the waveform output independently; when both match in one cycle, only B's select acts.
// - A flag clears only on writing 0 after reading it as 1.
// - Output select: 00 hold, 01 low, 10 high, 11 toggle.
// - Waveform output is 0 after reset until the first match.
// - Trigger edge field: 00 off, 01 rising, 10 falling, 11 both.
package tmrv_pkg;
  localparam logic [3:0] OFS_COUNT    = 4'h0;
  localparam logic [3:0] OFS_CONST_A  = 4'h4;
  localparam logic [3:0] OFS_CONST_B  = 4'h8;
  localparam logic [3:0] OFS_CONTROL0 = 4'hc;
  localparam logic [3:0] OFS_STATUS   = 4'h0;
  localparam logic [4:0] OFS_CONTROL1 = 5'h14;
  localparam logic [4:0] OFS_STAT5    = 5'h10;
  localparam logic [7:0] RST_COUNT    = 8'h00;
  localparam logic [7:0] RST_CONST    = 8'hff;
  localparam logic [7:0] RST_CONTROL0 = 8'h00;
  localparam logic [7:0] STATUS_RSVD  = 8'h10;
  localparam logic [7:0] CONTROL1_RSVD = 8'he2;
  localparam int         BIT_IE_B     = 7;
  localparam int         BIT_IE_A     = 6;
  localparam int         BIT_IE_OV    = 5;
  localparam int         BIT_FLAG_B   = 7;
  localparam int         BIT_FLAG_A   = 6;
  localparam int         BIT_FLAG_OV  = 5;
  localparam int         BIT_TRG_EN   = 2;
  localparam int         BIT_PRE_PICK = 0;
  localparam int         PRESCALE_W   = 7;
  localparam logic [1:0] CLR_NONE     = 2'h0;
  localparam logic [1:0] CLR_MATCH_A  = 2'h1;
  localparam logic [1:0] CLR_MATCH_B  = 2'h2;
  localparam logic [1:0] CLR_PIN      = 2'h3;
  localparam logic [1:0] OUT_HOLD     = 2'h0;
  localparam logic [1:0] OUT_LOW      = 2'h1;
  localparam logic [1:0] OUT_HIGH     = 2'h2;
  localparam logic [1:0] OUT_TOGGLE   = 2'h3;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage : tmrv_pkg

// *** src/tmrv_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module tmrv_timer (
  input  wire logic        SYS_CLK_I,
  input  wire logic        NRST_I,
  input  wire logic [4:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [4:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  input  wire logic        EXT_CLOCK_PIN_I,
  input  wire logic        EXT_RESET_PIN_I,
  input  wire logic        TRIGGER_PIN_I,
  output logic             WAVEFORM_OUT_PIN_O,
  output logic             IRQ_MATCH_A_O,
  output logic             IRQ_MATCH_B_O,
  output logic             IRQ_OVERFLOW_O
);

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [7:0] count_r;
  logic [7:0] const_a_r;
  logic [7:0] const_b_r;
  logic [7:0] control0_r;
  logic [4:0] control1_r;
  logic [3:0] out_sel_r;
  logic [2:0] flags_r;
  logic [2:0] flags_seen_r;
  logic       wave_r;
  logic       run_r;

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic       aw_held_r;
  logic       w_held_r;
  logic [4:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic       w_lane_r;
  logic       bvalid_r;
  logic       rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [1:0] bresp_r;
  logic       wr_fire;
  logic       rd_fire;

  function automatic logic known_addr(input logic [4:0] a);
    known_addr = (a == {1'b0, tmrv_pkg::OFS_COUNT}) || (a == {1'b0, tmrv_pkg::OFS_CONST_A}) ||
                 (a == {1'b0, tmrv_pkg::OFS_CONST_B}) || (a == {1'b0, tmrv_pkg::OFS_CONTROL0}) ||
                 (a == tmrv_pkg::OFS_STAT5) || (a == tmrv_pkg::OFS_CONTROL1);
  endfunction : known_addr

  assign AWREADY_O = !aw_held_r && !bvalid_r;
  assign WREADY_O  = !w_held_r && !bvalid_r;
  assign ARREADY_O = !rvalid_r;
  assign BVALID_O  = bvalid_r;
  assign BRESP_O   = bresp_r;
  assign RVALID_O  = rvalid_r;
  assign RDATA_O   = rdata_r;
  assign RRESP_O   = rresp_r;
  assign wr_fire   = aw_held_r && w_held_r && !bvalid_r;
  assign rd_fire   = ARVALID_I && !rvalid_r;

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 5'h00;
      w_data_r  <= 8'h00;
      w_lane_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= tmrv_pkg::RESP_OKAY;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= {AWADDR_I[4:2], 2'b00};
      end
      if (WVALID_I && WREADY_O) begin
        w_held_r <= 1'b1;
        w_data_r <= WDATA_I[7:0];
        w_lane_r <= WSTRB_I[0];
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= known_addr(aw_addr_r) ? tmrv_pkg::RESP_OKAY : tmrv_pkg::RESP_SLVERR;
      end else if (bvalid_r && BREADY_I) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  logic wr_do;
  assign wr_do = wr_fire && w_lane_r;

  logic rd_status;
  logic [4:0] rd_addr;
  assign rd_addr   = {ARADDR_I[4:2], 2'b00};
  assign rd_status = rd_fire && (rd_addr == tmrv_pkg::OFS_STAT5);

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= tmrv_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rresp_r  <= known_addr(rd_addr) ? tmrv_pkg::RESP_OKAY : tmrv_pkg::RESP_SLVERR;
      case (rd_addr)
        {1'b0, tmrv_pkg::OFS_COUNT}:    rdata_r <= {24'h000000, count_r};
        {1'b0, tmrv_pkg::OFS_CONST_A}:  rdata_r <= {24'h000000, const_a_r};
        {1'b0, tmrv_pkg::OFS_CONST_B}:  rdata_r <= {24'h000000, const_b_r};
        {1'b0, tmrv_pkg::OFS_CONTROL0}: rdata_r <= {24'h000000, control0_r};
        tmrv_pkg::OFS_STAT5:            rdata_r <= {24'h000000, flags_r, 1'b1, out_sel_r};
        tmrv_pkg::OFS_CONTROL1:         rdata_r <= {24'h000000, 3'b111, control1_r[4:2], 1'b1, control1_r[0]};
        default:                        rdata_r <= 32'h0000_0000;
      endcase
    end else if (rvalid_r && RREADY_I) begin
      rvalid_r <= 1'b0;
    end
  end

  logic wr_count;
  logic wr_const_a;
  logic wr_const_b;
  logic wr_status;
  assign wr_count   = wr_do && (aw_addr_r == {1'b0, tmrv_pkg::OFS_COUNT});
  assign wr_const_a = wr_do && (aw_addr_r == {1'b0, tmrv_pkg::OFS_CONST_A});
  assign wr_const_b = wr_do && (aw_addr_r == {1'b0, tmrv_pkg::OFS_CONST_B});
  assign wr_status  = wr_do && (aw_addr_r == tmrv_pkg::OFS_STAT5);

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      const_a_r  <= tmrv_pkg::RST_CONST;
      const_b_r  <= tmrv_pkg::RST_CONST;
      control0_r <= tmrv_pkg::RST_CONTROL0;
      control1_r <= 5'h00;
      out_sel_r  <= 4'h0;
    end else if (wr_do) begin
      if (wr_const_a) const_a_r <= w_data_r;
      if (wr_const_b) const_b_r <= w_data_r;
      if (aw_addr_r == {1'b0, tmrv_pkg::OFS_CONTROL0}) control0_r <= w_data_r;
      if (aw_addr_r == tmrv_pkg::OFS_CONTROL1) control1_r <= {w_data_r[4:2], 1'b0, w_data_r[0]};
      if (wr_status) out_sel_r <= w_data_r[3:0];
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  logic [2:0] pin_last_r;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pin_meta_r <= 3'b000;
      pin_sync_r <= 3'b000;
      pin_last_r <= 3'b000;
    end else begin
      pin_meta_r <= {TRIGGER_PIN_I, EXT_RESET_PIN_I, EXT_CLOCK_PIN_I};
      pin_sync_r <= pin_meta_r;
      pin_last_r <= pin_sync_r;
    end
  end
  assign pin_rise = pin_sync_r & ~pin_last_r;
  assign pin_fall = ~pin_sync_r & pin_last_r;

  // ------------------------------------------------------------
  // Prescaler and count tick
  // ------------------------------------------------------------
  logic [tmrv_pkg::PRESCALE_W-1:0] pre_r;
  logic [tmrv_pkg::PRESCALE_W-1:0] pre_nxt;
  logic [2:0] cks;
  logic [2:0] tap;
  logic       tick;
  assign cks     = control0_r[2:0];
  assign pre_nxt = pre_r + 7'h01;
  assign tap     = 3'(({1'b0, cks[1:0]} << 1) + {2'b00, control1_r[tmrv_pkg::BIT_PRE_PICK]} - 3'h1);

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) pre_r <= '0;
    else         pre_r <= pre_nxt;
  end

  always_comb begin
    tick = 1'b0;
    case (cks)
      3'b001, 3'b010, 3'b011: tick = pre_r[tap] && !pre_nxt[tap];
      3'b101:                 tick = pin_rise[0];
      3'b110:                 tick = pin_fall[0];
      3'b111:                 tick = pin_rise[0] || pin_fall[0];
      default:                tick = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Trigger, compare and clear
  // ------------------------------------------------------------
  logic [1:0] trg_edge;
  logic       trg_en;
  logic       trg_hit;
  logic       match_a;
  logic       match_b;
  logic       clr;
  logic       overflow;
  assign trg_edge = control1_r[4:3];
  assign trg_en   = control1_r[tmrv_pkg::BIT_TRG_EN];
  assign trg_hit  = (trg_edge[0] && pin_rise[2]) || (trg_edge[1] && pin_fall[2]);
  logic       same_a;
  logic       same_b;
  logic       same_a_r;
  logic       same_b_r;
  assign same_a   = count_r == const_a_r;
  assign same_b   = count_r == const_b_r;
  // A match is the first cycle of equality. On a slow tap the counter rests on a constant for many
  // clocks, and a level compare would toggle the output and set a cleared flag again on every clock.
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      same_a_r <= 1'b0;
      same_b_r <= 1'b0;
    end else begin
      same_a_r <= same_a;
      same_b_r <= same_b;
    end
  end
  assign match_a  = same_a && !same_a_r && !wr_const_a;
  assign match_b  = same_b && !same_b_r;
  always_comb begin
    case (control0_r[4:3])
      tmrv_pkg::CLR_MATCH_A: clr = match_a;
      tmrv_pkg::CLR_MATCH_B: clr = match_b;
      tmrv_pkg::CLR_PIN:     clr = pin_rise[1];
      default:               clr = 1'b0;
    endcase
  end
  assign overflow = tick && run_r && !clr && (count_r == 8'hff);

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) run_r <= 1'b1;
    else if (!trg_en) run_r <= 1'b1;
    else if (clr) run_r <= 1'b0;
    else if (trg_hit) run_r <= 1'b1;
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) count_r <= tmrv_pkg::RST_COUNT;
    else if (wr_count) count_r <= w_data_r;
    else if (clr) count_r <= 8'h00;
    else if (tick && run_r) count_r <= count_r + 8'h01;
  end

  // ------------------------------------------------------------
  // Flags: set beats clear; clear needs a prior read of 1
  // ------------------------------------------------------------
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  assign flag_set = {match_b, match_a, overflow};
  assign flag_clr = wr_status ? (flags_seen_r & ~w_data_r[7:5]) : 3'b000;

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      flags_r      <= 3'b000;
      flags_seen_r <= 3'b000;
    end else begin
      flags_r <= flag_set | (flags_r & ~flag_clr);
      if (rd_status) flags_seen_r <= flags_seen_r | flags_r;
      else           flags_seen_r <= flags_seen_r & ~flag_clr & flags_r;
    end
  end

  assign IRQ_MATCH_B_O  = flags_r[2] && control0_r[tmrv_pkg::BIT_IE_B];
  assign IRQ_MATCH_A_O  = flags_r[1] && control0_r[tmrv_pkg::BIT_IE_A];
  assign IRQ_OVERFLOW_O = flags_r[0] && control0_r[tmrv_pkg::BIT_IE_OV];

  // ------------------------------------------------------------
  // Waveform output; B wins when both act in one cycle
  // ------------------------------------------------------------
  function automatic logic out_act(input logic [1:0] sel, input logic cur);
    case (sel)
      tmrv_pkg::OUT_LOW:    out_act = 1'b0;
      tmrv_pkg::OUT_HIGH:   out_act = 1'b1;
      tmrv_pkg::OUT_TOGGLE: out_act = !cur;
      default:              out_act = cur;
    endcase
  endfunction : out_act

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) wave_r <= 1'b0;
    else if (match_b) wave_r <= out_act(out_sel_r[3:2], wave_r);
    else if (match_a) wave_r <= out_act(out_sel_r[1:0], wave_r);
  end
  assign WAVEFORM_OUT_PIN_O = wave_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  clear_on_a_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (control0_r[4:3] == tmrv_pkg::CLR_MATCH_A && match_a && !wr_count) |=> count_r == 8'h00)
    else $error("Counter not cleared on match A.");
  ovf_flag_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    overflow |=> flags_r[0])
    else $error("Overflow flag not set.");
  match_flag_a_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    match_a |=> flags_r[1])
    else $error("Flag A not set on match.");
  match_flag_b_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    match_b |=> flags_r[2])
    else $error("Flag B not set on match.");
  write_no_cmp_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (wr_const_a && !flags_r[1]) |=> !flags_r[1])
    else $error("Compare A active during write.");
  stop_on_clr_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (trg_en && clr && !wr_count) |=> !run_r && count_r == 8'h00)
    else $error("Count did not halt on clear.");
  out_high_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (match_a && !match_b && out_sel_r[1:0] == tmrv_pkg::OUT_HIGH) |=> WAVEFORM_OUT_PIN_O)
    else $error("Output not driven high on match A.");
  flag_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (flags_r[1] && !flags_seen_r[1] && !match_a) |=> flags_r[1])
    else $error("Flag cleared without prior read.");
  tick_count_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (tick && run_r && !clr && !wr_count) |=> count_r == $past(count_r) + 8'h01)
    else $error("Counter did not advance on tick.");
  wave_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (!match_a && !match_b) |=> $stable(WAVEFORM_OUT_PIN_O))
    else $error("Output changed without a match.");
  trig_start_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
    (trg_en && trg_hit && !clr) |=> run_r)
    else $error("Trigger edge did not start the count.");

endmodule : tmrv_timer
`default_nettype wire

// *** bench/axil_master.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Register bus master standing in for the processor.
// ----------------------------------------------------------------
module axil_master (
  input  wire logic        clk_i,
  output logic [4:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [4:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  initial begin
    awaddr_o = 5'h00;
    awvalid_o = 1'b0;
    wdata_o = 32'h0;
    wstrb_o = 4'h0;
    wvalid_o = 1'b0;
    bready_o = 1'b0;
    araddr_o = 5'h00;
    arvalid_o = 1'b0;
    rready_o = 1'b0;
  end

  // Each channel is released only at the edge that takes it.
  task automatic wr(input logic [4:0] a, input logic [7:0] v, output logic [1:0] r);
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= {24'h0, v};
    wstrb_o <= 4'hf;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (awready_i) awvalid_o <= 1'b0;
      if (wready_i) wvalid_o <= 1'b0;
      if (bvalid_i) break;
    end
    r = bresp_i;
    bready_o <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (arready_i) arvalid_o <= 1'b0;
      if (rvalid_i) break;
    end
    v = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask : rd
endmodule : axil_master
`default_nettype wire

// *** bench/tmrv_timer_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Timer bench driven through the register bus and the pins.
// ----------------------------------------------------------------
module tmrv_timer_tb;
  localparam logic [4:0] A_CNT = {1'b0, tmrv_pkg::OFS_COUNT};
  localparam logic [4:0] A_CA  = {1'b0, tmrv_pkg::OFS_CONST_A};
  localparam logic [4:0] A_CB  = {1'b0, tmrv_pkg::OFS_CONST_B};
  localparam logic [4:0] A_C0  = {1'b0, tmrv_pkg::OFS_CONTROL0};
  localparam logic [4:0] A_ST  = tmrv_pkg::OFS_STAT5;
  localparam logic [4:0] A_C1  = tmrv_pkg::OFS_CONTROL1;
  logic        clk;
  logic        nrst;
  logic [2:0]  pins;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
  logic        wav, irq_a, irq_b, irq_o, w;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cyc = 0;
  int          e;

  tmrv_timer i_dut (.SYS_CLK_I(clk), .NRST_I(nrst), .AWADDR_I(awaddr), .AWVALID_I(aw_v),
    .AWREADY_O(aw_r), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(w_v), .WREADY_O(w_r),
    .BRESP_O(bresp), .BVALID_O(b_v), .BREADY_I(b_r), .ARADDR_I(araddr), .ARVALID_I(ar_v),
    .ARREADY_O(ar_r), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(r_v), .RREADY_I(r_r),
    .EXT_CLOCK_PIN_I(pins[0]), .EXT_RESET_PIN_I(pins[1]), .TRIGGER_PIN_I(pins[2]),
    .WAVEFORM_OUT_PIN_O(wav), .IRQ_MATCH_A_O(irq_a), .IRQ_MATCH_B_O(irq_b), .IRQ_OVERFLOW_O(irq_o));

  axil_master i_cpu (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(aw_v), .awready_i(aw_r),
    .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(w_v), .wready_i(w_r), .bresp_i(bresp),
    .bvalid_i(b_v), .bready_o(b_r), .araddr_o(araddr), .arvalid_o(ar_v), .arready_i(ar_r),
    .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(r_v), .rready_o(r_r));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic w8(input logic [4:0] a, input logic [7:0] v);
    i_cpu.wr(a, v, r);
    chk("bresp", r, tmrv_pkg::RESP_OKAY);
  endtask : w8

  task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] x);
    i_cpu.rd(a, d, r);
    chk(nm, d, x);
    chk("rresp", r, tmrv_pkg::RESP_OKAY);
  endtask : rchk

  // The synchroniser needs three cycles, so each level is held for six.
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk);
      pins[k] <= 1'b1;
      repeat (6) @(posedge clk);
      pins[k] <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask : pulse

  initial begin
    nrst = 1'b0;
    pins = 3'h0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("wave", wav, 0);
    rchk("count", A_CNT, 32'h00);
    rchk("const_a", A_CA, 32'hff);
    rchk("const_b", A_CB, 32'hff);
    rchk("control0", A_C0, 32'h00);
    rchk("status", A_ST, 32'h10);
    rchk("control1", A_C1, 32'he2);
    i_cpu.rd(5'h18, d, r);
    chk("unmapped", {d[29:0], r}, 32'h2);
    i_cpu.wr(5'h18, 8'h00, r);
    chk("unmapped_wr", r, 32'h2);
    w8(A_CA, 8'h5a);
    rchk("const_a", A_CA, 32'h5a);
    w8(A_CNT, 8'hc3);
    rchk("count", A_CNT, 32'hc3);
    // External clock modes, then the stopped code 100.
    for (int i = 0; i < 4; i++) begin
      w8(A_CNT, 8'h00);
      w8(A_C0, 8'(i == 3 ? 4 : i + 5));
      pulse(0, 3);
      rchk("ext_count", A_CNT, i == 3 ? 0 : i == 2 ? 6 : 3);
    end
    w8(A_C0, 8'h25);
    w8(A_CNT, 8'hfe);
    pulse(0, 2);
    rchk("wrap", A_CNT, 32'h00);
    chk("irq_ov", irq_o, 1);
    w8(A_C0, 8'h05);
    chk("irq_ov_off", irq_o, 0);
    w8(A_ST, 8'h00);
    rchk("status", A_ST, 32'hb0);
    w8(A_ST, 8'h00);
    rchk("status", A_ST, 32'h10);
    // Prescaler taps over a fixed window; one tap apart differs by a factor of two.
    w8(A_CA, 8'h05);
    for (int i = 0; i < 6; i++) begin
      w8(A_C1, 8'(i % 2));
      w8(A_C0, 8'(i / 2 + 1));
      w8(A_CNT, 8'h00);
      repeat (512) @(posedge clk);
      i_cpu.rd(A_CNT, d, r);
      e = 512 >> (i + 2);
      chk("rate", (d + 1 >= e) && (d <= e + 1), 1);
    end
    w8(A_C1, 8'h00);
    w8(A_C0, 8'h00);
    rchk("status", A_ST, 32'h50);
    w8(A_ST, 8'h03);
    w8(A_CNT, 8'h00);
    w8(A_C0, 8'h49);
    for (int i = 0; i < 200 && irq_a !== 1'b1; i++) @(posedge clk);
    w8(A_C0, 8'h48);
    chk("irq_a", irq_a, 1);
    chk("wave", wav, 1);
    i_cpu.rd(A_CNT, d, r);
    chk("cleared", d < 5, 1);
    // Output select B codes with clear on match B.
    w8(A_CB, 8'h01);
    w8(A_C0, 8'h95);
    w = wav;
    for (int c = 0; c < 4; c++) begin
      w8(A_ST, {4'h0, 2'(c), 2'h0});
      w8(A_CNT, 8'h00);
      pulse(0, 1);
      w = c == 0 ? w : c == 1 ? 1'b0 : c == 2 ? 1'b1 : ~w;
      chk("wave_b", wav, w);
    end
    chk("irq_b", irq_b, 1);
    // Pin clear halts the count; the selected trigger edge restarts it.
    w8(A_C0, 8'h1d);
    for (int c = 0; c < 4; c++) begin
      w8(A_C1, {3'h0, 2'(c), 3'h4});
      w8(A_CNT, 8'h10);
      pulse(1, 1);
      pulse(0, 1);
      rchk("halted", A_CNT, 32'h00);
      pulse(2, 1);
      pulse(0, 2);
      rchk("trig", A_CNT, c == 0 ? 0 : 2);
    end
    rchk("control1", A_C1, 32'hfe);
    conclude();
  end
endmodule : tmrv_timer_tb
`default_nettype wire
